// *** rtl/dbc_regs.svh ***
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH

// ****************************************************************
// Boot-select codes and link figures
// ****************************************************************
`define DBC_MODE_DUAL 3'b110
`define DBC_MODE_HOST 3'b111
`define DBC_ATTEMPTS 3
`define DBC_PAGE_LSB 12
`define DBC_PAGE_W 12
`define DBC_ADDR_W 24
`define DBC_INT_START 24'h000000

// ****************************************************************
// Timing, clock period 10 ns
// ****************************************************************
`define DBC_CLK_NS 10
`define DBC_TCPU_CLK_NS 40
`define DBC_SCLK_HALF_MIN ((`DBC_TCPU_CLK_NS / 2 + `DBC_CLK_NS - 1) / `DBC_CLK_NS)
`define DBC_SCLK_HALF 8
`define DBC_RESTART_NS 80
`define DBC_RESTART_CYC ((`DBC_RESTART_NS + `DBC_CLK_NS - 1) / `DBC_CLK_NS)
`define DBC_READY_DLY_NS 100
`define DBC_READY_DLY_CYC ((`DBC_READY_DLY_NS + `DBC_CLK_NS - 1) / `DBC_CLK_NS)

// ****************************************************************
// Host controller register map
// ****************************************************************
`define DBC_REG_CTRL 4'h0
`define DBC_REG_DATA 4'h4
`define DBC_REG_RBACK 4'h8
`define DBC_REG_STATUS 4'hc
`define DBC_CTRL_RESTART 0
`define DBC_CTRL_MODE_LSB 1
`define DBC_CTRL_SELECT 4
`define DBC_CTRL_RESET 32'h0000_0000
`define DBC_RESP_OKAY 2'b00
`define DBC_RESP_SLVERR 2'b10

`endif

// *** rtl/dbc_pkg.sv ***
package dbc_pkg;

   // ****************************************************************
   // State encodings
   // ****************************************************************
   typedef enum logic [6:0] {
      DEV_RESET = 7'b000_0001,
      DEV_SAMPLE = 7'b000_0010,
      DEV_LOAD_REQ = 7'b000_0100,
      DEV_LOAD_WAIT = 7'b000_1000,
      DEV_HOST = 7'b001_0000,
      DEV_DONE = 7'b010_0000,
      DEV_FAIL = 7'b100_0000
   } dbc_dev_state_e;

   typedef enum logic [3:0] {
      HST_IDLE = 4'b0001,
      HST_HIGH = 4'b0010,
      HST_LOW = 4'b0100,
      HST_WAIT = 4'b1000
   } dbc_host_state_e;

endpackage

// *** rtl/dbc_if.sv ***
`timescale 1ns/10ps

interface dbc_if;
   logic restart_n; // Active-low restart from host
   logic [2:0] mode; // Boot-select pins
   logic ready; // Device can accept programming
   logic done; // Configuration complete
   logic sclk; // Host port clock
   logic port_select_n; // Host port select, active low
   logic we_n; // 0 write, 1 read
   logic [7:0] d_host_o; // Host data out
   logic d_host_oe; // Host drives data bus
   logic [7:0] d_dev_o; // Device data out
   logic d_dev_oe; // Device drives data bus
   logic [7:0] d; // Resolved bus level

   // Weak pull-up when nobody drives
   assign d = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 8'hff);

   modport device (input restart_n, mode, sclk, port_select_n, we_n, d,
                   output ready, done, d_dev_o, d_dev_oe);
   modport host (output restart_n, mode, sclk, port_select_n, we_n, d_host_o, d_host_oe,
                 input ready, done, d);
endinterface

// *** rtl/dbc_device.sv ***
// Functional notes
// [RULE1] Boot code 110: external flash tried first
// [RULE2] External flash fails: fall back to internal
// [RULE3] Three attempts per source before switching
// [RULE4] Internal flash always starts at zero
// [RULE5] Each external attempt has own start address
// [RULE6] Start address only bits 23:12 settable
// [RULE7] Retry-forever variant keeps fixed start address
// [RULE8] Boot-select sampled at ready rising edge
// [RULE9] Host drives boot-select 111 for host port
// [RULE10] Host holds select low throughout configuration
// [RULE11] Write-enable: 0 writes, 1 reads
// [RULE12] Data bus input while configuring, readback after
// [RULE13] Bytes travel most-significant bit first
// [RULE14] Byte captured on port clock falling edge
// [RULE15] Ready high only while programming allowed
// [RULE16] Done raised on success; low means failure
// [RULE17] Restart on power cycle or restart pulse
// [RULE18] Host port unusable when restart pin is GPIO
// [RULE19] Select, write-enable sampled with data; select-high ignored
// [RULE20] All attempts failed: done low, await restart
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dbc_regs.svh"

module dbc_device #(
   parameter int ATTEMPTS = `DBC_ATTEMPTS, // Load attempts per source
   parameter bit RETRY_FOREVER = 1'b0, // Variant that keeps retrying
   parameter int READY_DLY = `DBC_READY_DLY_CYC // Cycles from restart to ready
) (
   input wire logic clk, // System clock
   input wire logic srst, // Sync reset, acts as power cycle
   dbc_if.device pins, // Configuration pins
   input wire logic restart_is_gpio, // Restart pin was reused as GPIO
   input wire logic [ATTEMPTS*`DBC_PAGE_W-1:0] boot_page, // Start pages from bitstream
   output logic fl_req, // Load attempt request, level
   output logic fl_src_int, // 0 external, 1 internal flash
   output logic [`DBC_ADDR_W-1:0] fl_addr, // Start address of attempt
   input wire logic fl_done, // Attempt finished, pulse
   input wire logic fl_ok, // Attempt succeeded, with fl_done
   output logic [7:0] cfg_byte, // Byte taken from host port
   output logic cfg_byte_valid, // Byte strobe, one cycle
   input wire logic cfg_end, // Bitstream ended well, pulse
   input wire logic cfg_err, // Bitstream error, pulse
   input wire logic [7:0] rb_byte // Readback byte for host reads
);

   localparam int AW = (ATTEMPTS > 1) ? $clog2(ATTEMPTS) : 1;
   localparam int SW = 15;

   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   if (ATTEMPTS < 1 || ATTEMPTS > 8) begin : g_bad_att
      $error("ATTEMPTS must lie in 1..8");
   end
   if (READY_DLY < 3 || READY_DLY > 4096) begin : g_bad_dly
      $error("READY_DLY below 3 would latch a boot code still in the sync");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [SW-1:0] sync1;
   logic [SW-1:0] sync2;
   logic sclk_prev;

   // Two flops on every pin; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1 <= 15'h7bff; // Pin idle levels; port clock rests low, no false edge
         sync2 <= 15'h7bff;
      end else begin
         sync1 <= {pins.restart_n, pins.mode, pins.sclk, pins.port_select_n,
                   pins.we_n, pins.d};
         sync2 <= sync1;
      end
   end

   logic restart_n_s;
   logic [2:0] mode_s;
   logic sclk_s;
   logic psel_n_s;
   logic we_n_s;
   logic [7:0] d_s;
   assign restart_n_s = sync2[14];
   assign mode_s = sync2[13:11];
   assign sclk_s = sync2[10];
   assign psel_n_s = sync2[9];
   assign we_n_s = sync2[8];
   assign d_s = sync2[7:0];

   // Port clock edge finder; all bus pins share the same delay
   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
      end
   end

   logic sclk_fall;
   logic restart_hold;
   logic bus_write;
   logic bus_read;
   assign sclk_fall = sclk_prev & ~sclk_s; // [RULE14]
   assign restart_hold = ~restart_n_s & ~restart_is_gpio; // [RULE17] [RULE18]
   assign bus_write = sclk_fall & ~psel_n_s & ~we_n_s; // [RULE19] [RULE11] [RULE10]
   assign bus_read = sclk_fall & ~psel_n_s & we_n_s; // [RULE19] [RULE11]

   // ****************************************************************
   // Configuration sequencer
   // ****************************************************************
   dbc_pkg::dbc_dev_state_e state;
   logic [2:0] mode_lat;
   logic [AW-1:0] attempt;
   logic [12:0] dly_cnt;
   logic first_round;

   // Ready comes up after a settling delay, boot code latched then
   always_ff @(posedge clk) begin
      if (srst || restart_hold) begin
         state <= dbc_pkg::DEV_RESET; // [RULE17]
         dly_cnt <= 13'h0000;
         mode_lat <= 3'h0;
      end else begin
         case (state)
            dbc_pkg::DEV_RESET: begin
               if (dly_cnt == 13'(READY_DLY - 1)) begin
                  state <= dbc_pkg::DEV_SAMPLE;
                  mode_lat <= mode_s; // [RULE8]
               end else begin
                  dly_cnt <= dly_cnt + 13'h0001;
               end
            end
            dbc_pkg::DEV_SAMPLE: begin
               if (mode_lat == `DBC_MODE_DUAL) begin
                  state <= dbc_pkg::DEV_LOAD_REQ; // [RULE1]
               end else if (mode_lat == `DBC_MODE_HOST && !restart_is_gpio) begin
                  state <= dbc_pkg::DEV_HOST; // [RULE18]
               end else begin
                  state <= dbc_pkg::DEV_FAIL;
               end
            end
            dbc_pkg::DEV_LOAD_REQ: begin
               state <= dbc_pkg::DEV_LOAD_WAIT;
            end
            dbc_pkg::DEV_LOAD_WAIT: begin
               if (fl_done && fl_ok) begin
                  state <= dbc_pkg::DEV_DONE;
               end else if (fl_done) begin
                  if (attempt != AW'(ATTEMPTS - 1) || !fl_src_int) begin
                     state <= dbc_pkg::DEV_LOAD_REQ; // [RULE2] [RULE3]
                  end else if (RETRY_FOREVER) begin
                     state <= dbc_pkg::DEV_LOAD_REQ; // [RULE7]
                  end else begin
                     state <= dbc_pkg::DEV_FAIL; // [RULE20]
                  end
               end
            end
            dbc_pkg::DEV_HOST: begin
               if (cfg_err) begin
                  state <= dbc_pkg::DEV_FAIL;
               end else if (cfg_end) begin
                  state <= dbc_pkg::DEV_DONE;
               end
            end
            dbc_pkg::DEV_DONE: begin
               state <= dbc_pkg::DEV_DONE;
            end
            dbc_pkg::DEV_FAIL: begin
               state <= dbc_pkg::DEV_FAIL; // [RULE20]
            end
            default: begin
               state <= dbc_pkg::DEV_RESET;
            end
         endcase
      end
   end

   // ****************************************************************
   // Attempt bookkeeping
   // ****************************************************************
   // Source and attempt number step only on a failed attempt
   always_ff @(posedge clk) begin
      if (srst || restart_hold || state == dbc_pkg::DEV_SAMPLE) begin
         attempt <= '0;
         fl_src_int <= 1'b0; // [RULE1]
         first_round <= 1'b1;
      end else if (state == dbc_pkg::DEV_LOAD_WAIT && fl_done && !fl_ok) begin
         if (attempt != AW'(ATTEMPTS - 1)) begin
            attempt <= attempt + AW'(1); // [RULE3]
         end else begin
            attempt <= '0;
            fl_src_int <= ~fl_src_int; // [RULE2] [RULE3]
            if (fl_src_int) begin
               first_round <= 1'b0;
            end
         end
      end
   end

   // Start address per attempt; internal source pinned to zero
   always_ff @(posedge clk) begin
      if (srst || restart_hold) begin
         fl_req <= 1'b0;
         fl_addr <= `DBC_INT_START;
      end else if (state == dbc_pkg::DEV_LOAD_REQ) begin
         fl_req <= 1'b1;
         if (fl_src_int) begin
            fl_addr <= `DBC_INT_START; // [RULE4]
         end else if (!first_round) begin
            // Later rounds reuse the first page: no address change
            fl_addr <= {boot_page[`DBC_PAGE_W-1:0], `DBC_PAGE_LSB'(0)}; // [RULE7]
         end else begin
            fl_addr <= {boot_page[attempt*`DBC_PAGE_W +: `DBC_PAGE_W],
                        `DBC_PAGE_LSB'(0)}; // [RULE5] [RULE6]
         end
      end else if (fl_done) begin
         fl_req <= 1'b0;
      end
   end

   // ****************************************************************
   // Status pins
   // ****************************************************************
   // Ready drops on failure so the host sees it at once
   always_ff @(posedge clk) begin
      if (srst || restart_hold) begin
         pins.ready <= 1'b0;
         pins.done <= 1'b0;
      end else begin
         pins.ready <= (state != dbc_pkg::DEV_RESET) && (state != dbc_pkg::DEV_FAIL)
                       && !(state == dbc_pkg::DEV_HOST && cfg_err)
                       && !(state == dbc_pkg::DEV_LOAD_WAIT && fl_done && !fl_ok
                            && fl_src_int && attempt == AW'(ATTEMPTS - 1)
                            && !RETRY_FOREVER); // [RULE15] [RULE16]
         pins.done <= (state == dbc_pkg::DEV_DONE)
                      || (state == dbc_pkg::DEV_LOAD_WAIT && fl_done && fl_ok)
                      || (state == dbc_pkg::DEV_HOST && cfg_end && !cfg_err); // [RULE16]
      end
   end

   // ****************************************************************
   // Host port data path
   // ****************************************************************
   // Bus bit 7 is the first bitstream bit, kept in place
   always_ff @(posedge clk) begin
      if (srst || restart_hold) begin
         cfg_byte <= 8'h00;
         cfg_byte_valid <= 1'b0;
      end else begin
         cfg_byte_valid <= (state == dbc_pkg::DEV_HOST) && bus_write; // [RULE14]
         if (state == dbc_pkg::DEV_HOST && bus_write) begin
            cfg_byte <= d_s; // [RULE13]
         end
      end
   end

   // Drive readback only after success; released on select or write
   always_ff @(posedge clk) begin
      if (srst || restart_hold) begin
         pins.d_dev_oe <= 1'b0;
         pins.d_dev_o <= 8'h00;
      end else if (state == dbc_pkg::DEV_DONE && mode_lat == `DBC_MODE_HOST && bus_read) begin
         pins.d_dev_oe <= 1'b1; // [RULE12]
         pins.d_dev_o <= rb_byte;
      end else if (psel_n_s || !we_n_s || state != dbc_pkg::DEV_DONE) begin
         pins.d_dev_oe <= 1'b0; // [RULE12]
      end
   end

endmodule // dbc_device

// *** rtl/dbc_host.sv ***
`timescale 1ns/10ps
`include "dbc_regs.svh"

module dbc_host #(
   parameter int SCLK_HALF = `DBC_SCLK_HALF, // Cycles per port clock half
   parameter int RESTART_CYC = `DBC_RESTART_CYC // Restart pulse length
) (
   input wire logic clk, // System clock
   input wire logic srst, // Sync reset, active high
   dbc_if.host pins, // Configuration pins
   input wire logic [3:0] s_awaddr, // AXI write address
   input wire logic s_awvalid, // AXI write address valid
   output logic s_awready, // AXI write address ready
   input wire logic [31:0] s_wdata, // AXI write data
   input wire logic [3:0] s_wstrb, // AXI write strobes
   input wire logic s_wvalid, // AXI write data valid
   output logic s_wready, // AXI write data ready
   output logic [1:0] s_bresp, // AXI write response
   output logic s_bvalid, // AXI write response valid
   input wire logic s_bready, // AXI write response ready
   input wire logic [3:0] s_araddr, // AXI read address
   input wire logic s_arvalid, // AXI read address valid
   output logic s_arready, // AXI read address ready
   output logic [31:0] s_rdata, // AXI read data
   output logic [1:0] s_rresp, // AXI read response
   output logic s_rvalid, // AXI read data valid
   input wire logic s_rready // AXI read data ready
);

   if (SCLK_HALF < `DBC_SCLK_HALF_MIN || SCLK_HALF > 252) begin : g_bad_half
      $error("SCLK_HALF below port clock minimum or too large");
   end
   if (RESTART_CYC < 1 || RESTART_CYC > 255) begin : g_bad_rst
      $error("RESTART_CYC must lie in 1..255");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [9:0] sync1;
   logic [9:0] sync2;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1 <= 10'h000;
         sync2 <= 10'h000;
      end else begin
         sync1 <= {pins.ready, pins.done, pins.d};
         sync2 <= sync1;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic do_write;
   logic busy;
   logic wr_data;
   logic wr_rback;
   logic wr_ok;
   dbc_pkg::dbc_host_state_e state;
   logic [31:0] ctrl;
   logic [7:0] rback;

   assign do_write = ~s_awready & ~s_wready & ~s_bvalid;
   assign busy = (state != dbc_pkg::HST_IDLE);
   assign wr_data = do_write && aw_addr == `DBC_REG_DATA && !busy;
   assign wr_rback = do_write && aw_addr == `DBC_REG_RBACK && !busy;
   assign wr_ok = aw_addr == `DBC_REG_CTRL || wr_data || wr_rback;

   // Address and data taken in either order; answer after both
   always_ff @(posedge clk) begin
      if (srst) begin
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         s_bvalid <= 1'b0;
         s_bresp <= `DBC_RESP_OKAY;
         aw_addr <= 4'h0;
         w_data <= 32'h0000_0000;
      end else begin
         if (s_awvalid && s_awready) begin
            s_awready <= 1'b0;
            aw_addr <= {s_awaddr[3:2], 2'b00};
         end
         if (s_wvalid && s_wready) begin
            s_wready <= 1'b0;
            w_data <= s_wdata;
         end
         if (do_write) begin
            s_bvalid <= 1'b1;
            // Busy port or the read-only status word answers with an error
            s_bresp <= wr_ok ? `DBC_RESP_OKAY : `DBC_RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
         end
      end
   end

   // Read answered one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (srst) begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= `DBC_RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rresp <= `DBC_RESP_OKAY;
         case ({s_araddr[3:2], 2'b00})
            `DBC_REG_CTRL: s_rdata <= ctrl;
            `DBC_REG_RBACK: s_rdata <= {24'h000000, rback};
            `DBC_REG_STATUS: s_rdata <= {29'h0, busy, sync2[8], sync2[9]};
            default: begin
               s_rdata <= 32'h0000_0000;
               s_rresp <= `DBC_RESP_SLVERR;
            end
         endcase
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // ****************************************************************
   // Control pins
   // ****************************************************************
   logic [7:0] rst_cnt;

   // Control word; byte lane 0 only. Restart bit self-clears
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= `DBC_CTRL_RESET;
      end else if (do_write && aw_addr == `DBC_REG_CTRL && s_wstrb[0]) begin
         ctrl <= {24'h000000, w_data[7:0] & 8'h1e};
      end
   end

   // Boot code and select follow the control word
   always_ff @(posedge clk) begin
      if (srst) begin
         pins.mode <= 3'h0;
         pins.port_select_n <= 1'b1;
         pins.restart_n <= 1'b1;
         rst_cnt <= 8'h00;
      end else begin
         pins.mode <= ctrl[`DBC_CTRL_MODE_LSB +: 3]; // [RULE9]
         pins.port_select_n <= ~ctrl[`DBC_CTRL_SELECT]; // [RULE10]
         if (do_write && aw_addr == `DBC_REG_CTRL && s_wstrb[0]
             && w_data[`DBC_CTRL_RESTART]) begin
            pins.restart_n <= 1'b0; // [RULE17]
            rst_cnt <= 8'(RESTART_CYC - 1);
         end else if (rst_cnt != 8'h00) begin
            rst_cnt <= rst_cnt - 8'h01;
         end else begin
            pins.restart_n <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Byte cycle engine
   // ****************************************************************
   logic [8:0] cnt;
   logic is_read;

   // Clock high, then falling edge; reads wait for device answer
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= dbc_pkg::HST_IDLE;
         cnt <= 9'h000;
         is_read <= 1'b0;
         pins.sclk <= 1'b0;
         pins.we_n <= 1'b1;
         pins.d_host_o <= 8'h00;
         pins.d_host_oe <= 1'b0;
         rback <= 8'h00;
      end else begin
         case (state)
            dbc_pkg::HST_IDLE: begin
               if (wr_data || wr_rback) begin
                  state <= dbc_pkg::HST_HIGH;
                  cnt <= 9'(SCLK_HALF - 1);
                  is_read <= wr_rback;
                  pins.sclk <= 1'b1;
                  pins.we_n <= wr_rback; // [RULE11]
                  pins.d_host_o <= w_data[7:0]; // [RULE13]
                  pins.d_host_oe <= wr_data;
               end
            end
            dbc_pkg::HST_HIGH: begin
               if (cnt == 9'h000) begin
                  state <= dbc_pkg::HST_LOW;
                  cnt <= 9'(SCLK_HALF - 1);
                  pins.sclk <= 1'b0;
               end else begin
                  cnt <= cnt - 9'h001;
               end
            end
            dbc_pkg::HST_LOW: begin
               if (cnt != 9'h000) begin
                  cnt <= cnt - 9'h001;
               end else if (is_read) begin
                  state <= dbc_pkg::HST_WAIT;
                  cnt <= 9'(2 * SCLK_HALF + 7);
               end else begin
                  state <= dbc_pkg::HST_IDLE;
                  pins.d_host_oe <= 1'b0;
               end
            end
            dbc_pkg::HST_WAIT: begin
               if (cnt == 9'h000) begin
                  state <= dbc_pkg::HST_IDLE;
                  rback <= sync2[7:0]; // [RULE12]
               end else begin
                  cnt <= cnt - 9'h001;
               end
            end
            default: begin
               state <= dbc_pkg::HST_IDLE;
            end
         endcase
      end
   end

endmodule // dbc_host

// *** test/dbc_props.sv ***
`timescale 1ns/10ps
// ********
// Pin checks across the link
// ********
module dbc_props (
   input wire logic clk, // System clock
   input wire logic srst, // Sync reset
   input wire logic restart_n, // Restart pin
   input wire logic [2:0] mode, // Boot code
   input wire logic ready, // Device ready
   input wire logic done, // Device done
   input wire logic sclk, // Port clock
   input wire logic port_select_n, // Port select
   input wire logic we_n, // Direction
   input wire logic d_dev_oe, // Device drives bus
   input wire logic d_host_oe // Host drives bus
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Host byte capture point
   sequence wr_edge_s;
      $fell(sclk) && d_host_oe;
   endsequence
   pulse_len_a: assert property ($fell(restart_n) |-> !restart_n[*8] ##1 restart_n)
      else $error("restart pulse length wrong");
   restart_drop_a: assert property ($fell(restart_n) |-> ##[1:6] !ready && !done)
      else $error("restart did not clear device");
   done_ready_a: assert property (done |-> ready)
      else $error("done without ready");
   sel_low_a: assert property (wr_edge_s |-> !port_select_n && !we_n)
      else $error("byte edge without select or write");
   sclk_high_a: assert property ($rose(sclk) |=> sclk[*3] ##1 !sclk)
      else $error("port clock high phase wrong");
   dev_oe_a: assert property (d_dev_oe |-> done && !d_host_oe)
      else $error("device drives bus too early");
   bad_mode_a: assert property ($rose(ready) && !(mode inside {3'b110, 3'b111})
      |-> ##[1:6] !ready)
      else $error("unknown boot code kept ready");
   done_rise_a: assert property ($rose(done) |-> $past(ready, 2))
      else $error("done rose without ready");
   fail_done_a: assert property ($fell(ready) |-> !done)
      else $error("ready fell with done high");
endmodule // dbc_props

// *** test/testbench.sv ***
`timescale 1ns/10ps
// ********
// Host end driven over AXI4-Lite; device end fed by a flash stand-in
// ********
module testbench;
   logic clk, srst, fl_req, fl_src_int, fl_seen, fl_done, fl_ok, cfg_end, cfg_byte_valid;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] rresp, bresp;
   logic [23:0] fl_addr;
   logic [7:0] cfg_byte, rb_byte, b;
   logic [35:0] boot_page;
   logic [33:0] exp_q[$];
   int err_count, tests_run, fails_left;
   dbc_if link();
   dbc_device #(.READY_DLY(3)) u_dbc_device (.clk(clk), .srst(srst), .pins(link.device),
      .restart_is_gpio(1'b0), .boot_page(boot_page), .fl_req(fl_req), .fl_src_int(fl_src_int),
      .fl_addr(fl_addr), .fl_done(fl_done), .fl_ok(fl_ok), .cfg_byte(cfg_byte),
      .cfg_byte_valid(cfg_byte_valid), .cfg_end(cfg_end), .cfg_err(1'b0), .rb_byte(rb_byte));
   dbc_host #(.SCLK_HALF(4)) u_dbc_host (.clk(clk), .srst(srst), .pins(link.host),
      .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
      .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
      .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
   dbc_props u_props (.clk(clk), .srst(srst), .restart_n(link.restart_n), .mode(link.mode),
      .ready(link.ready), .done(link.done), .sclk(link.sclk), .port_select_n(link.port_select_n),
      .we_n(link.we_n), .d_dev_oe(link.d_dev_oe), .d_host_oe(link.d_host_oe));
   // Compare one result against the oldest note, or against e0 when q is clear
   task automatic chk(input string nm, input logic [33:0] got, e0 = 34'h0, input bit q = 1);
      logic [33:0] e;
      e = q ? (exp_q.size() ? exp_q.pop_front() : 'x) : e0;
      tests_run++;
      if (got !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask
   // Flash stand-in answers each attempt; watcher takes results
   always @(posedge clk) begin
      fl_done <= 1'b0;
      if (fl_req && !fl_seen) begin
         chk("fl_addr", 34'({fl_src_int, fl_addr}));
         fl_ok <= (fails_left == 0);
         fails_left <= fails_left - 1;
         fl_done <= 1'b1;
      end
      fl_seen <= fl_req && !fl_done;
      if (cfg_byte_valid) chk("cfg_byte", 34'(cfg_byte));
      if (rvalid && rready) chk("rdata", {rresp, rdata});
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cuts a hang well past the expected run length
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      logic ap = 1'b1, wp = 1'b1;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp) begin
         @(posedge clk);
         ap = ap && !awready;
         wp = wp && !wready;
         awvalid <= ap;
         wvalid <= wp;
      end
      while (!bvalid) @(posedge clk);
      chk("bresp", 34'(bresp), 34'h0, 1'b0);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      @(posedge clk);
      exp_q.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      rready <= 1'b0;
   endtask
   // Bounded wait for a done/ready pair, then let status sync settle
   task automatic wait_st(input logic [1:0] st);
      repeat (300) if ({link.done, link.ready} !== st) @(posedge clk);
      chk("status", 34'({link.done, link.ready}), 34'(st), 1'b0);
      repeat (4) @(posedge clk);
   endtask
   // Restart with a boot code; n failed flash attempts, then success if n is below 6
   task automatic boot(input logic [2:0] m, input int n);
      for (int i = 0; i < 6 && i <= n; i++)
         exp_q.push_back(i < 3 ? 34'({1'b0, boot_page[i*12+:12], 12'h000}) : 34'h1000000);
      fails_left = n;
      wr(4'h0, {27'h0, m == 3'b111, m, 1'b1});
      wait_st(2'b01);
   endtask
   task automatic wrap_up;
      if (err_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      {srst, fl_seen, fl_done, fl_ok, cfg_end, awvalid, wvalid, bready, arvalid, rready} = 10'h200;
      {awaddr, araddr, wdata} = '0;
      void'($urandom(91));
      boot_page = 36'({$urandom, $urandom});
      rb_byte = 8'($urandom);
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      boot(3'b110, 4);
      wait_st(2'b11);
      rd(4'hc, 34'h3);
      boot(3'b110, 6);
      wait_st(2'b00);
      rd(4'hc, 34'h0);
      boot(3'b101, -1);
      wait_st(2'b00);
      boot(3'b111, -1);
      for (int i = 0; i < 3; i++) begin
         b = 8'($urandom);
         exp_q.push_back(34'(b));
         wr(4'h4, 32'(b));
         repeat (20) @(posedge clk);
      end
      cfg_end <= 1'b1;
      @(posedge clk);
      cfg_end <= 1'b0;
      wait_st(2'b11);
      wr(4'h8, 32'h0);
      repeat (40) @(posedge clk);
      rd(4'h8, 34'(rb_byte));
      rd(4'h0, 34'h1e);
      wrap_up();
   end
endmodule // testbench
